// ===== vbiaf_params.svh
// Constants of the blanking-interval ancillary framer and raw capture.
// Assumes inclusion by bare name from the package and the top module.
`ifndef VBIAF_PARAMS_SVH
`define VBIAF_PARAMS_SVH
// ==========================================================
// Register byte offsets
`define VBIAF_A_CTRL 5'h00
`define VBIAF_A_RAW_START 5'h04
`define VBIAF_A_RAW_STOP 5'h08
`define VBIAF_A_LINE_MASK 5'h0C
`define VBIAF_A_BLANK 5'h10
`define VBIAF_A_SC_INC 5'h14
`define VBIAF_A_STATUS 5'h18
// ==========================================================
// Control fields and reset values
`define VBIAF_C_TT_EN 0
`define VBIAF_C_TM_EN 1
`define VBIAF_C_RAW_EN 2
`define VBIAF_C_RAW_ALL 3
`define VBIAF_C_STD_LO 4
`define VBIAF_C_VSIGN 6
`define VBIAF_STD_NTSC 2'h0
`define VBIAF_STD_PAL 2'h1
`define VBIAF_STD_PALM 2'h2
`define VBIAF_R_CTRL 7'h00
`define VBIAF_R_RAW_START 11'h07A
`define VBIAF_R_RAW_STOP 11'h34A
`define VBIAF_R_MASK 19'h0_1FFE
`define VBIAF_R_BLANK 8'h10
// ==========================================================
// Packet words
`define VBIAF_PRE0 8'h00
`define VBIAF_PRE1 8'hFF
`define VBIAF_TT_DID 6'h34
`define VBIAF_TM_DID 6'h35
`define VBIAF_DBN 6'h01
`define VBIAF_TT_DC 6'h16
`define VBIAF_TM_DC 6'h03
`define VBIAF_TT_WORDS 7'd88
`define VBIAF_TT_NIBS 7'd86
`define VBIAF_TM_WORDS 7'd12
`define VBIAF_TM_ZERO 7'd4
`define VBIAF_ZN_525B 7'd16
`define VBIAF_ZN_SYSC 7'd18
// ==========================================================
// Bounds of the always-blanked sync lines: S starts them, F is the first line after
`define VBIAF_NT_F1 10'd10
`define VBIAF_NT_F2 10'd272
`define VBIAF_NT_S2 10'd264
`define VBIAF_PA_F1 10'd6
`define VBIAF_PA_F2 10'd318
`define VBIAF_PA_S2 10'd311
`define VBIAF_PA_S1 10'd623
`define VBIAF_PM_F1 10'd7
`define VBIAF_PM_F2 10'd269
`define VBIAF_PM_S2 10'd261
`define VBIAF_PM_S1 10'd523
`endif

// ===== vbiaf_pkg.sv
// Types shared by the framer modules.
// Assumes the constants header sits in the include path.
`include "vbiaf_params.svh"
package vbiaf_pkg;
    // ==========================================================
    // Packet sequencer states
    typedef enum logic [2:0] {ST_IDLE, ST_PRE, ST_HDR, ST_PAY, ST_CRC} vbiaf_st_t;
    // Software-visible settings
    typedef struct packed {
        logic [6:0] ctrl;
        logic [10:0] raw_start;
        logic [10:0] raw_stop;
        logic [18:0] mask;
        logic [7:0] blank;
        logic [31:0] sc_inc;
    } vbiaf_regs_t;
    // Whole state of the top module
    typedef struct packed {
        vbiaf_st_t st;
        logic kind;
        logic [6:0] cnt;
        logic [6:0] crc;
        vbiaf_st_t out_st;
        logic out_kind;
        logic [6:0] out_idx;
        logic [7:0] pix;
        logic pvalid;
        logic rvalid;
        logic tt_pend;
        logic tt_req;
        logic tm_req;
        logic [1:0] tt_std;
        logic [10:0] raw_cnt;
        logic raw_line;
        logic sync_line;
        vbiaf_regs_t regs;
        logic ack;
        logic [31:0] rdata;
    } vbiaf_state_t;
endpackage : vbiaf_pkg

// ===== vbiaf_ram.sv
// Holding store for one sliced teletext line, one byte per entry.
// Assumes one writer and one reader on the same clock.
`timescale 1ns/100ps
module vbiaf_ram #(
    parameter int DW = 8,
    parameter int DEPTH = 43,
    parameter int AW = 6
) (
    input wire logic CORE_CLK,
    input wire logic we,
    input wire logic [AW-1:0] waddr,
    input wire logic [DW-1:0] wdata,
    input wire logic [AW-1:0] raddr,
    output logic [DW-1:0] rdata
);
    // ==========================================================
    // Parameter check
    if (DEPTH > (1 << AW) || DW < 1) begin : g_chk
        $error("vbiaf_ram: depth does not fit address width");
    end
    logic [DW-1:0] mem [DEPTH];
    // Registered read; no reset since contents are data only
    always_ff @(posedge CORE_CLK) begin
        if (we && int'(waddr) < DEPTH) begin
            mem[waddr] <= wdata;
        end
        rdata <= (int'(raddr) < DEPTH) ? mem[raddr] : '0;
    end
endmodule : vbiaf_ram

// ===== vbiaf_top.sv
// Ancillary packet framer (teletext, encoder timing) and raw capture.
// Assumes a slicer filling the line store and a timing generator
// giving line pulses, all synchronous to CORE_CLK.
`timescale 1ns/100ps
`include "vbiaf_params.svh"
module vbiaf_top
    import vbiaf_pkg::*;
#(
    parameter int MASK_LINES = 19,
    parameter int CNT_W = 11
) (
    input wire logic CORE_CLK,
    input wire logic ARST_N,
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    input wire logic WB_WE_I,
    input wire logic [4:0] WB_ADR_I,
    input wire logic [3:0] WB_SEL_I,
    input wire logic [31:0] WB_DAT_I,
    output logic [31:0] WB_DAT_O,
    output logic WB_ACK_O,
    input wire logic PIX_EN,
    input wire logic RAW_EN,
    input wire logic LINE_START,
    input wire logic HBLANK_START,
    input wire logic [9:0] LINE_NUM,
    input wire logic FIELD,
    input wire logic LINE_BLANKED,
    input wire logic [7:0] RAW_SAMPLE,
    input wire logic TT_WE,
    input wire logic [5:0] TT_WADDR,
    input wire logic [7:0] TT_WDATA,
    input wire logic TT_DONE,
    input wire logic TT_625,
    input wire logic TT_SYS_C,
    output logic [7:0] PIX_OUT,
    output logic VBI_PACKET_VALID,
    output logic RAW_VALID
);
    // ==========================================================
    // Elaboration check
    if (MASK_LINES != 19 || CNT_W != 11) begin : g_chk
        $error("vbiaf_top: mask lines and count width are fixed");
    end
    vbiaf_state_t cur_reg, cur_next;
    logic [7:0] mem_q;
    logic [7:0] word;
    logic [5:0] w6;
    logic [31:0] nib_sh;
    logic [1:0] std;
    logic [9:0] f_first;
    logic [9:0] rel;
    logic sync_now;
    logic wb_req;
    logic [31:0] wmask;
    logic [6:0] zero_n;
    logic [8:0] diff;
    // Parity-protected word: P15 inverse of P14, P14 even parity
    function automatic logic [7:0] pw(input logic [5:0] d);
        pw = {~(^d), ^d, d};
    endfunction : pw
    // ==========================================================
    // Line store
    vbiaf_ram #(.DW(8), .DEPTH(43), .AW(6)) u_ram (
        .CORE_CLK(CORE_CLK),
        .we(TT_WE),
        .waddr(TT_WADDR),
        .wdata(TT_WDATA),
        .raddr(cur_next.cnt[6:1]),
        .rdata(mem_q)
    );
    // ==========================================================
    // Line classification, standard dependent
    assign std = cur_reg.regs.ctrl[`VBIAF_C_STD_LO +: 2];
    always_comb begin
        unique case (std)
            `VBIAF_STD_PAL: begin
                f_first = FIELD ? `VBIAF_PA_F2 : `VBIAF_PA_F1;
                sync_now = LINE_NUM >= `VBIAF_PA_S1 ||
                    LINE_NUM < `VBIAF_PA_F1 ||
                    (LINE_NUM >= `VBIAF_PA_S2 && LINE_NUM < `VBIAF_PA_F2);
            end
            `VBIAF_STD_PALM: begin
                f_first = FIELD ? `VBIAF_PM_F2 : `VBIAF_PM_F1;
                sync_now = LINE_NUM >= `VBIAF_PM_S1 ||
                    LINE_NUM < `VBIAF_PM_F1 ||
                    (LINE_NUM >= `VBIAF_PM_S2 && LINE_NUM < `VBIAF_PM_F2);
            end
            default: begin
                f_first = FIELD ? `VBIAF_NT_F2 : `VBIAF_NT_F1;
                sync_now = LINE_NUM < `VBIAF_NT_F1 ||
                    (LINE_NUM >= `VBIAF_NT_S2 && LINE_NUM < `VBIAF_NT_F2);
            end
        endcase
        rel = LINE_NUM - f_first;
    end
    // Leading nibbles forced to zero for the shorter systems
    assign zero_n = cur_reg.tt_std[0] ? `VBIAF_ZN_SYSC :
        (cur_reg.tt_std[1] ? 7'd0 : `VBIAF_ZN_525B);
    assign nib_sh = cur_reg.regs.sc_inc << {3'(cur_reg.cnt - `VBIAF_TM_ZERO), 2'b00};
    assign diff = {1'b0, RAW_SAMPLE} - {1'b0, cur_reg.regs.blank};
    // ==========================================================
    // Word under the sequencer
    always_comb begin
        w6 = '0;
        word = '0;
        unique case (cur_reg.st)
            ST_PRE: word = (cur_reg.cnt == 7'd0) ? `VBIAF_PRE0 : `VBIAF_PRE1;
            ST_HDR: begin
                if (cur_reg.cnt == 7'd0) begin
                    w6 = cur_reg.kind ? `VBIAF_TT_DID : `VBIAF_TM_DID;
                end else if (cur_reg.cnt == 7'd1) begin
                    w6 = `VBIAF_DBN;
                end else begin
                    w6 = cur_reg.kind ? `VBIAF_TT_DC : `VBIAF_TM_DC;
                end
                word = pw(w6);
            end
            ST_PAY: begin
                if (cur_reg.kind) begin
                    // Teletext nibble, high nibble of each byte first
                    if (cur_reg.cnt < `VBIAF_TT_NIBS && cur_reg.cnt >= zero_n) begin
                        w6[3:0] = cur_reg.cnt[0] ? mem_q[3:0] : mem_q[7:4];
                    end
                    if (cur_reg.cnt == 7'd0) begin
                        w6[5:4] = cur_reg.tt_std;
                    end
                end else if (cur_reg.cnt >= `VBIAF_TM_ZERO) begin
                    w6[3:0] = nib_sh[31:28];
                    if (cur_reg.cnt == `VBIAF_TM_ZERO) begin
                        // Phase sign forced low in NTSC
                        w6[5] = (std != `VBIAF_STD_NTSC) &&
                            cur_reg.regs.ctrl[`VBIAF_C_VSIGN];
                    end
                end
                word = pw(w6);
            end
            ST_CRC: word = {~cur_reg.crc[6], cur_reg.crc};
            default: word = '0;
        endcase
    end
    // ==========================================================
    // Bus decode helpers
    assign wb_req = WB_CYC_I && WB_STB_I && !cur_reg.ack;
    assign wmask = {{8{WB_SEL_I[3]}}, {8{WB_SEL_I[2]}},
        {8{WB_SEL_I[1]}}, {8{WB_SEL_I[0]}}};
    // ==========================================================
    // Next state
    always_comb begin
        logic [31:0] old32;
        logic [31:0] new32;
        old32 = '0;
        new32 = '0;
        cur_next = cur_reg;
        // Register bus, one wait state, write lands with ack
        cur_next.ack = wb_req;
        if (wb_req) begin
            unique case (WB_ADR_I & 5'h1C)
                `VBIAF_A_CTRL: old32 = 32'(cur_reg.regs.ctrl);
                `VBIAF_A_RAW_START: old32 = 32'(cur_reg.regs.raw_start);
                `VBIAF_A_RAW_STOP: old32 = 32'(cur_reg.regs.raw_stop);
                `VBIAF_A_LINE_MASK: old32 = 32'(cur_reg.regs.mask);
                `VBIAF_A_BLANK: old32 = 32'(cur_reg.regs.blank);
                `VBIAF_A_SC_INC: old32 = cur_reg.regs.sc_inc;
                `VBIAF_A_STATUS: old32 = {29'h0, cur_reg.raw_line,
                    cur_reg.tt_pend, cur_reg.st != ST_IDLE};
                default: old32 = '0;
            endcase
            cur_next.rdata = WB_WE_I ? '0 : old32;
            new32 = (old32 & ~wmask) | (WB_DAT_I & wmask);
            if (WB_WE_I) begin
                unique case (WB_ADR_I & 5'h1C)
                    `VBIAF_A_CTRL: cur_next.regs.ctrl = new32[6:0];
                    `VBIAF_A_RAW_START: cur_next.regs.raw_start = new32[10:0];
                    `VBIAF_A_RAW_STOP: cur_next.regs.raw_stop = new32[10:0];
                    `VBIAF_A_LINE_MASK: cur_next.regs.mask = new32[18:0];
                    `VBIAF_A_BLANK: cur_next.regs.blank = new32[7:0];
                    `VBIAF_A_SC_INC: cur_next.regs.sc_inc = new32;
                    default: ;
                endcase
            end
        end
        // Line requests; a capture ending now keeps its pending flag
        if (HBLANK_START) begin
            cur_next.tm_req = cur_reg.regs.ctrl[`VBIAF_C_TM_EN];
            if (cur_reg.tt_pend) begin
                cur_next.tt_req = 1'b1;
                cur_next.tt_pend = 1'b0;
            end
        end
        if (TT_DONE && cur_reg.regs.ctrl[`VBIAF_C_TT_EN]) begin
            cur_next.tt_pend = 1'b1;
            cur_next.tt_std = {TT_625, TT_SYS_C};
        end
        // Packet sequencer, one word per pixel enable
        if (PIX_EN) begin
            cur_next.pix = word;
            cur_next.pvalid = cur_reg.st != ST_IDLE;
            cur_next.out_st = cur_reg.st;
            cur_next.out_kind = cur_reg.kind;
            cur_next.out_idx = cur_reg.cnt;
            cur_next.cnt = cur_reg.cnt + 7'd1;
            if (cur_reg.st == ST_HDR || cur_reg.st == ST_PAY) begin
                cur_next.crc = cur_reg.crc + word[6:0];
            end
            unique case (cur_reg.st)
                ST_IDLE: begin
                    cur_next.cnt = '0;
                    cur_next.crc = '0;
                    // Short timing packet first, so it clears SAV
                    if (cur_reg.tm_req) begin
                        cur_next.st = ST_PRE;
                        cur_next.kind = 1'b0;
                        cur_next.tm_req = 1'b0;
                    end else if (cur_reg.tt_req) begin
                        cur_next.st = ST_PRE;
                        cur_next.kind = 1'b1;
                        cur_next.tt_req = 1'b0;
                    end
                end
                ST_PRE, ST_HDR: if (cur_reg.cnt == 7'd2) begin
                    cur_next.cnt = '0;
                    cur_next.st = (cur_reg.st == ST_PRE) ? ST_HDR : ST_PAY;
                end
                ST_PAY: if (cur_reg.cnt == (cur_reg.kind ?
                        `VBIAF_TT_WORDS - 7'd1 : `VBIAF_TM_WORDS - 7'd1)) begin
                    cur_next.st = ST_CRC;
                end
                ST_CRC: cur_next.st = ST_IDLE;
            endcase
        end
        // Raw capture, judged once per line at its start
        if (LINE_START) begin
            cur_next.raw_cnt = '0;
            cur_next.sync_line = sync_now;
            cur_next.raw_line = cur_reg.regs.ctrl[`VBIAF_C_RAW_EN] && !sync_now &&
                (cur_reg.regs.ctrl[`VBIAF_C_RAW_ALL] ||
                (LINE_BLANKED && LINE_NUM >= f_first &&
                rel < 10'd19 && cur_reg.regs.mask[rel[4:0]]));
        end else if (RAW_EN) begin
            cur_next.raw_cnt = cur_reg.raw_cnt + 11'd1;
            cur_next.rvalid = cur_reg.raw_line &&
                cur_reg.raw_cnt >= cur_reg.regs.raw_start &&
                cur_reg.raw_cnt < cur_reg.regs.raw_stop;
            // Packets own the pins; raw fills the rest of the line
            if (cur_next.rvalid && !cur_next.pvalid) begin
                cur_next.pix = diff[8] ? 8'h00 : diff[7:0];
            end
        end
    end
    // ==========================================================
    // State register
    always_ff @(posedge CORE_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            cur_reg <= '0;
            cur_reg.st <= ST_IDLE;
            cur_reg.out_st <= ST_IDLE;
            cur_reg.regs.ctrl <= `VBIAF_R_CTRL;
            cur_reg.regs.raw_start <= `VBIAF_R_RAW_START;
            cur_reg.regs.raw_stop <= `VBIAF_R_RAW_STOP;
            cur_reg.regs.mask <= `VBIAF_R_MASK;
            cur_reg.regs.blank <= `VBIAF_R_BLANK;
        end else begin
            cur_reg <= cur_next;
        end
    end
    assign PIX_OUT = cur_reg.pix;
    assign VBI_PACKET_VALID = cur_reg.pvalid;
    assign RAW_VALID = cur_reg.rvalid && !cur_reg.pvalid;
    assign WB_DAT_O = cur_reg.rdata;
    assign WB_ACK_O = cur_reg.ack;
    // ==========================================================
    // Checks; helper keeps an independent checksum of words seen
    logic pe_d;
    logic [6:0] sum_h;
    always_ff @(posedge CORE_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            pe_d <= 1'b0;
            sum_h <= '0;
        end else begin
            pe_d <= PIX_EN;
            if (pe_d && cur_reg.out_st == ST_PRE) begin
                sum_h <= '0;
            end else if (pe_d && (cur_reg.out_st == ST_HDR ||
                    cur_reg.out_st == ST_PAY)) begin
                sum_h <= sum_h + PIX_OUT[6:0];
            end
        end
    end
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (!ARST_N);
    preamble_first_a: assert property ($rose(VBI_PACKET_VALID) |->
        PIX_OUT == `VBIAF_PRE0 && cur_reg.out_st == ST_PRE)
        else $error("packet did not open with 00");
    valid_span_a: assert property ($fell(VBI_PACKET_VALID) |->
        $past(cur_reg.out_st) == ST_CRC)
        else $error("valid dropped before checksum");
    parity_bit_a: assert property (VBI_PACKET_VALID &&
        (cur_reg.out_st == ST_HDR || cur_reg.out_st == ST_PAY) |->
        PIX_OUT[6] == ^PIX_OUT[5:0])
        else $error("bad even parity bit");
    inv_p15_a: assert property (VBI_PACKET_VALID &&
        cur_reg.out_st != ST_PRE |-> PIX_OUT[7] != PIX_OUT[6])
        else $error("P15 not inverse of P14");
    checksum_sum_a: assert property (pe_d && VBI_PACKET_VALID &&
        cur_reg.out_st == ST_CRC |-> PIX_OUT[6:0] == sum_h)
        else $error("checksum mismatch");
    tt_zero_a: assert property (VBI_PACKET_VALID && cur_reg.out_kind &&
        cur_reg.out_st == ST_PAY && cur_reg.out_idx < zero_n |->
        PIX_OUT[3:0] == 4'h0)
        else $error("unused teletext bits not zero");
    raw_sync_a: assert property (RAW_VALID |->
        cur_reg.raw_line && !cur_reg.sync_line)
        else $error("raw data on a sync line");
    raw_window_a: assert property ($rose(cur_reg.rvalid) |->
        $past(cur_reg.raw_cnt) >= cur_reg.regs.raw_start &&
        $past(cur_reg.raw_cnt) < cur_reg.regs.raw_stop)
        else $error("raw sample outside window");
    raw_level_a: assert property ($rose(RAW_VALID) && $past(RAW_EN) &&
        $stable(cur_reg.regs.blank) |-> PIX_OUT == (($past(RAW_SAMPLE) >
        cur_reg.regs.blank) ? $past(RAW_SAMPLE) - cur_reg.regs.blank : 8'h00))
        else $error("blanking level not removed");
    tm_start_a: assert property (PIX_EN && cur_reg.st == ST_IDLE &&
        cur_reg.tm_req |=> cur_reg.st == ST_PRE && !cur_reg.kind)
        else $error("timing packet not started");
    cv_tt_c: cover property (pe_d && cur_reg.out_kind && cur_reg.out_st == ST_CRC);
    cv_tm_c: cover property (pe_d && !cur_reg.out_kind && cur_reg.out_st == ST_CRC);
    cv_raw_c: cover property ($rose(RAW_VALID));
    cv_both_c: cover property (cur_reg.raw_line && VBI_PACKET_VALID);
endmodule : vbiaf_top

// ===== vbiaf_capture.sv
// Far-side capture model: paces pixel words, collects packet bytes.
// Assumes the framer's outputs are synchronous to CORE_CLK.
`timescale 1ns/100ps
module vbiaf_capture (
    input wire logic CORE_CLK,
    input wire logic ARST_N,
    input wire logic [1:0] pace,
    input wire logic [7:0] PIX_OUT,
    input wire logic VBI_PACKET_VALID,
    output logic PIX_EN
);
    logic [1:0] cnt_reg;
    logic [7:0] words[$];
    // ==========================================================
    // Pixel pacing; a slow pace stretches every word
    always_ff @(posedge CORE_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            cnt_reg <= 2'h0;
            PIX_EN <= 1'b0;
        end else begin
            cnt_reg <= (cnt_reg >= pace) ? 2'h0 : cnt_reg + 2'h1;
            PIX_EN <= (cnt_reg >= pace);
        end
    end
    // Word is taken at the enable that retires it
    always @(posedge CORE_CLK) begin
        if (PIX_EN && VBI_PACKET_VALID) words.push_back(PIX_OUT);
    end
endmodule : vbiaf_capture

// ===== vbiaf_top_bench.sv
// Self-checking bench: registers, packet framing, raw capture.
// Assumes the capture model paces PIX_EN and records packet words.
`timescale 1ns/100ps
module vbiaf_top_bench;
    logic core_clk = 0, arst_n = 0, cyc = 0, stb = 0, we = 0;
    logic raw_en = 0, line_start = 0, hbl = 0, field = 0, blanked = 0;
    logic tt_we = 0, tt_done = 0, t625 = 0, sysc = 0;
    logic ack, raw_valid, valid, pix_en;
    logic [4:0] adr = 0;
    logic [31:0] wdat = 0, rdat, dat_o;
    logic [9:0] line_num = 0;
    logic [7:0] sample = 0, pix, tt_wdata = 0;
    logic [5:0] tt_waddr = 0;
    logic [1:0] pace = 0;
    logic [7:0] exp_q[$];
    logic [6:0] sum;
    int mismatches = 0, n_compared = 0;
    vbiaf_top dut (.CORE_CLK(core_clk), .ARST_N(arst_n), .WB_CYC_I(cyc),
        .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(4'hF),
        .WB_DAT_I(wdat), .WB_DAT_O(dat_o), .WB_ACK_O(ack), .PIX_EN(pix_en),
        .RAW_EN(raw_en), .LINE_START(line_start), .HBLANK_START(hbl),
        .LINE_NUM(line_num), .FIELD(field), .LINE_BLANKED(blanked),
        .RAW_SAMPLE(sample), .TT_WE(tt_we), .TT_WADDR(tt_waddr),
        .TT_WDATA(tt_wdata), .TT_DONE(tt_done), .TT_625(t625),
        .TT_SYS_C(sysc), .PIX_OUT(pix), .VBI_PACKET_VALID(valid),
        .RAW_VALID(raw_valid));
    vbiaf_capture far (.CORE_CLK(core_clk), .ARST_N(arst_n), .pace(pace),
        .PIX_OUT(pix), .VBI_PACKET_VALID(valid), .PIX_EN(pix_en));
    // ==========================================================
    // Clock, 200 MHz
    initial forever #2.5 core_clk = ~core_clk;
    task automatic chk(input logic [31:0] got, input logic [31:0] want);
        n_compared++;
        if (got !== want) begin
            mismatches++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got,
                want);
        end
    endtask : chk
    // Classic single cycle; waits for ack, never assumes a latency
    task automatic wb(input logic w, input logic [4:0] a,
        input logic [31:0] d);
        @(posedge core_clk);
        cyc <= 1;
        stb <= 1;
        we <= w;
        adr <= a;
        wdat <= d;
        // Only the watchdog ends a wait that never sees ack
        do begin
            @(posedge core_clk);
        end while (ack !== 1'b1);
        rdat = dat_o;
        cyc <= 0;
        stb <= 0;
        we <= 0;
    endtask : wb
    task automatic pw(input logic [5:0] d);
        logic [7:0] w;
        w = {~(^d), ^d, d};
        exp_q.push_back(w);
        sum = sum + w[6:0];
    endtask : pw
    task automatic head(input logic [5:0] did, input logic [5:0] dc);
        exp_q.push_back(8'h00);
        exp_q.push_back(8'hFF);
        exp_q.push_back(8'hFF);
        sum = 7'h00;
        pw(did);
        pw(6'h01);
        pw(dc);
    endtask : head
    // ==========================================================
    // Reset values, read-only and unmapped places
    task automatic t_regs;
        logic [4:0] a[8] = '{0, 4, 8, 12, 16, 20, 24, 28};
        logic [31:0] e[8] = '{0, 32'h7A, 32'h34A, 32'h1FFE, 32'h10, 0, 0, 0};
        foreach (a[i]) begin
            wb(0, a[i], 0);
            chk(rdat, e[i]);
        end
        wb(1, 5'h18, '1);
        wb(1, 5'h1C, '1);
        wb(1, 5'h04, '1);
        wb(0, 5'h18, 0);
        chk(rdat, 0);
        wb(0, 5'h1C, 0);
        chk(rdat, 0);
        wb(0, 5'h04, 0);
        chk(rdat, 32'h7FF);
    endtask : t_regs
    // Timing packet then teletext packet in one blanking
    task automatic t_pkt(input logic [1:0] std, input logic f6,
        input logic fc, input logic [1:0] p);
        logic [31:0] sc = 32'h9E37_79B9;
        logic [7:0] b;
        logic [3:0] nb;
        int n;
        pace <= p;
        wb(1, 5'h14, sc);
        wb(1, 5'h00, {25'h0, 1'b1, std, 4'h3});
        for (n = 0; n < 43; n++) begin
            @(posedge core_clk);
            tt_we <= 1;
            tt_waddr <= n[5:0];
            tt_wdata <= 8'h5A ^ n[7:0];
        end
        @(posedge core_clk);
        tt_we <= 0;
        tt_done <= 1;
        t625 <= f6;
        sysc <= fc;
        @(posedge core_clk);
        tt_done <= 0;
        hbl <= 1;
        far.words.delete();
        @(posedge core_clk);
        hbl <= 0;
        exp_q.delete();
        head(6'h35, 6'h03);
        repeat (4) pw(6'h00);
        for (n = 7; n >= 0; n--) pw({n == 7 && std != 0, 1'b0, sc[4*n+:4]});
        exp_q.push_back({~sum[6], sum});
        head(6'h34, 6'h16);
        for (n = 0; n < 86; n++) begin
            b = 8'h5A ^ n[8:1];
            nb = n[0] ? b[3:0] : b[7:4];
            if ((fc && n < 18) || (!fc && !f6 && n < 16)) nb = 4'h0;
            pw({n == 0 ? {f6, fc} : 2'b00, nb});
        end
        pw(6'h00);
        pw(6'h00);
        exp_q.push_back({~sum[6], sum});
        for (n = 0; n < 2000 && far.words.size() < exp_q.size(); n++)
            @(posedge core_clk);
        repeat (12) @(posedge core_clk);
        chk(far.words.size(), exp_q.size());
        foreach (exp_q[i]) chk(far.words[i], exp_q[i]);
    endtask : t_pkt
    // One line of raw capture; start 2, stop 4, blanking 0x18
    task automatic t_raw(input logic [6:0] ct, input logic [9:0] ln,
        input logic bl, input logic on);
        logic [7:0] s;
        int c;
        wb(1, 5'h00, {25'h0, ct});
        @(posedge core_clk);
        line_num <= ln;
        field <= (ln > 10'd263);
        blanked <= bl;
        line_start <= 1;
        @(posedge core_clk);
        line_start <= 0;
        for (c = 0; c < 6; c++) begin
            s = 8'h04 + 8'(c * 8);
            sample <= s;
            raw_en <= 1;
            @(posedge core_clk);
            raw_en <= 0;
            @(negedge core_clk);
            chk(raw_valid, on && c >= 2 && c < 4);
            if (on && c >= 2 && c < 4) chk(pix, s > 8'h18 ? s - 8'h18 : 0);
            @(posedge core_clk);
        end
    endtask : t_raw
    task automatic print_verdict;
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : print_verdict
    // ==========================================================
    // Main sequence
    initial begin
        repeat (5) @(posedge core_clk);
        arst_n <= 1;
        t_regs();
        t_pkt(2'h0, 0, 0, 2'h0);
        t_pkt(2'h1, 1, 0, 2'h2);
        t_pkt(2'h2, 0, 1, 2'h1);
        wb(1, 5'h04, 2);
        wb(1, 5'h08, 4);
        wb(1, 5'h10, 32'h18);
        t_raw(7'h04, 10'd11, 1, 1);
        t_raw(7'h04, 10'd10, 1, 0);
        t_raw(7'h04, 10'd20, 0, 0);
        t_raw(7'h0C, 10'd100, 0, 1);
        t_raw(7'h0C, 10'd5, 1, 0);
        t_raw(7'h0C, 10'd271, 1, 0);
        t_raw(7'h0C, 10'd272, 1, 1);
        t_raw(7'h1C, 10'd313, 1, 0);
        t_raw(7'h1C, 10'd318, 1, 1);
        t_raw(7'h2C, 10'd262, 1, 0);
        t_raw(7'h2C, 10'd269, 1, 1);
        print_verdict();
    end
    // Watchdog, well beyond the one thousand or so cycles the run needs
    initial begin
        repeat (20000) @(posedge core_clk);
        mismatches++;
        print_verdict();
    end
endmodule : vbiaf_top_bench
